// *** pfscg_top.sv ***
`timescale 1ns/1ns
module pfscg_top (
    input  wire logic        aclk,            // 20 MHz clock
    input  wire logic        aresetn,         // Sync reset, active low
    input  wire logic [7:0]  s_axi_awaddr,    // Write address
    input  wire logic        s_axi_awvalid,   // Write address valid
    output logic             s_axi_awready,   // Write address ready
    input  wire logic [31:0] s_axi_wdata,     // Write data
    input  wire logic [3:0]  s_axi_wstrb,     // Byte enables
    input  wire logic        s_axi_wvalid,    // Write data valid
    output logic             s_axi_wready,    // Write data ready
    output logic [1:0]       s_axi_bresp,     // Write response
    output logic             s_axi_bvalid,    // Write response valid
    input  wire logic        s_axi_bready,    // Write response ready
    input  wire logic [7:0]  s_axi_araddr,    // Read address
    input  wire logic        s_axi_arvalid,   // Read address valid
    output logic             s_axi_arready,   // Read address ready
    output logic [31:0]      s_axi_rdata,     // Read data
    output logic [1:0]       s_axi_rresp,     // Read response
    output logic             s_axi_rvalid,    // Read data valid
    input  wire logic        s_axi_rready,    // Read data ready
    input  wire logic [5:0]  pad_in,          // Pad levels C0-3, D0-1
    output logic [5:0]       pad_out,         // Pad drive values
    output logic [5:0]       pad_oe,          // Pad output enables
    input  wire logic [5:0]  gpio_out,        // Port GPIO drive data
    output logic [5:0]       gpio_in,         // Pad levels to GPIO
    input  wire logic [3:0]  timer_out,       // Timer B channel outputs
    input  wire logic [3:0]  timer_output_enable, // Timer B drive enables
    output logic [3:0]       timer_in,        // Timer B channel inputs
    output logic [3:0]       decoder_in,      // Phase A, B, index, home
    input  wire logic [3:0]  spi_out,         // SPI clk, MOSI, MISO, SS
    input  wire logic [3:0]  spi_oe,          // SPI per-signal drive
    output logic [3:0]       spi_in,          // SPI pad inputs
    input  wire logic        chip_select_two,   // EXTERNAL_MEMORY_INTERFACE chip select 2
    input  wire logic        chip_select_three, // EXTERNAL_MEMORY_INTERFACE chip select 3
    input  wire logic        second_can_transmit, // CAN transmit data
    output logic             second_can_receive,  // CAN receive data
    output logic [15:0]      clk_en,          // Per-peripheral enables
    output logic [15:0]      periph_clk       // Gated peripheral clocks
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [pfscg_pkg::SEL_W-1:0] sel_reg;
    logic [pfscg_pkg::PCE_W-1:0] pce_reg;
    logic [pfscg_pkg::NPAD-1:0]  pe_reg;
    logic [pfscg_pkg::NPAD-1:0]  dir_reg;
    logic [7:0]                  awaddr_reg;
    logic                        aw_have_reg;
    logic                        w_have_reg;
    logic [31:0]                 wdata_reg;
    logic [3:0]                  wstrb_reg;
    logic [15:0]                 en_neg_reg;
    logic [5:0]                  pad_out_next;
    logic [5:0]                  pad_oe_next;
    logic                        do_write;
    logic [5:0]                  widx;
    logic [5:0]                  ridx;

    assign widx     = awaddr_reg[7:2];
    assign ridx     = s_axi_araddr[7:2];
    assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;

    // ----------------------------------------------------------------
    // Bus write channels
    // ----------------------------------------------------------------

    // Address and data are caught separately, in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_reg <= 1'b0;
            awaddr_reg  <= 8'h00;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_have_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
        end
        else if (do_write)
            aw_have_reg <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_have_reg <= 1'b0;
            wdata_reg  <= 32'h00000000;
            wstrb_reg  <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_have_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
        end
        else if (do_write)
            w_have_reg <= 1'b0;
    end

    // Ready only while the holding slot is free, so nothing is dropped
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !aw_have_reg && !s_axi_awready
                             && !s_axi_bvalid;
            s_axi_wready  <= !w_have_reg && !s_axi_wready
                             && !s_axi_bvalid;
        end
    end

    // Response after both halves; unknown index answers an error
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= pfscg_pkg::RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            if (widx == pfscg_pkg::SEL_IDX || widx == pfscg_pkg::PCE_IDX
                || widx == pfscg_pkg::PAD_CTL_IDX
                || widx == pfscg_pkg::PAD_STAT_IDX)
                s_axi_bresp <= pfscg_pkg::RESP_OKAY;
            else
                s_axi_bresp <= pfscg_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------

    // Only six select bits exist; upper writes fall away
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sel_reg <= pfscg_pkg::SEL_RST;
        else if (do_write && widx == pfscg_pkg::SEL_IDX && wstrb_reg[0])
            sel_reg <= wdata_reg[pfscg_pkg::SEL_W-1:0];
    end

    // Clock enables, all running out of reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pce_reg <= pfscg_pkg::PCE_RST;
        else if (do_write && widx == pfscg_pkg::PCE_IDX)
        begin
            if (wstrb_reg[0])
                pce_reg[7:0] <= wdata_reg[7:0];
            if (wstrb_reg[1])
                pce_reg[15:8] <= wdata_reg[15:8];
        end
    end

    // Per-pad peripheral enable and GPIO direction
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pe_reg  <= pfscg_pkg::PE_RST;
            dir_reg <= pfscg_pkg::DIR_RST;
        end
        else if (do_write && widx == pfscg_pkg::PAD_CTL_IDX)
        begin
            if (wstrb_reg[0])
                pe_reg <= wdata_reg[pfscg_pkg::CTL_PE_LSB +: 6];
            if (wstrb_reg[1])
                dir_reg <= wdata_reg[pfscg_pkg::CTL_DIR_LSB +: 6];
        end
    end

    // ----------------------------------------------------------------
    // Bus read channel
    // ----------------------------------------------------------------

    // One read at a time; address is taken only while idle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= pfscg_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= pfscg_pkg::RESP_OKAY;
            case (ridx)
                pfscg_pkg::SEL_IDX:
                    s_axi_rdata <= {26'h0000000, sel_reg};
                pfscg_pkg::PCE_IDX:
                    s_axi_rdata <= {16'h0000, pce_reg};
                pfscg_pkg::PAD_CTL_IDX:
                    s_axi_rdata <= {18'h00000, dir_reg, 2'h0, pe_reg};
                pfscg_pkg::PAD_STAT_IDX:
                    s_axi_rdata <= {18'h00000, pad_oe, 2'h0, pad_in};
                default:
                begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= pfscg_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
        else
            s_axi_arready <= !s_axi_arready;
    end

    // ----------------------------------------------------------------
    // Port C pad steering
    // ----------------------------------------------------------------

    // Same mux per pin: GPIO, decoder/timer or SPI
    generate
        for (genvar i = 0; i < pfscg_pkg::NPC; i++)
        begin : g_pc
            assign pad_out_next[i] = !pe_reg[i] ? gpio_out[i]
                                   : sel_reg[i] ? spi_out[i]
                                   : timer_out[i];
            assign pad_oe_next[i]  = !pe_reg[i] ? dir_reg[i]
                                   : sel_reg[i] ? spi_oe[i]
                                   : timer_output_enable[i];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Port D pad steering
    // ----------------------------------------------------------------

    // Chip selects and CAN transmit always drive; CAN receive never
    assign pad_out_next[4] = !pe_reg[pfscg_pkg::PD0] ? gpio_out[4]
                           : sel_reg[4] ? second_can_transmit
                           : chip_select_two;
    assign pad_oe_next[4]  = !pe_reg[pfscg_pkg::PD0] ? dir_reg[4]
                           : 1'b1;
    assign pad_out_next[5] = !pe_reg[pfscg_pkg::PD1] ? gpio_out[5]
                           : chip_select_three;
    assign pad_oe_next[5]  = !pe_reg[pfscg_pkg::PD1] ? dir_reg[5]
                           : !sel_reg[5];

    // Pad drive, registered so the pins never see mux glitches
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pad_out <= 6'h00;
            pad_oe  <= 6'h00;
        end
        else
        begin
            pad_out <= pad_out_next;
            pad_oe  <= pad_oe_next;
        end
    end

    // ----------------------------------------------------------------
    // Inputs handed to the peripherals
    // ----------------------------------------------------------------

    // Unselected timer, decoder and SPI see idle levels, CAN receive recessive; GPIO always sees the pads
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            gpio_in            <= 6'h00;
            timer_in           <= 4'h0;
            decoder_in         <= 4'h0;
            spi_in             <= 4'h0;
            second_can_receive <= 1'b1;
        end
        else
        begin
            gpio_in    <= pad_in;
            timer_in   <= pad_in[3:0] & pe_reg[3:0] & ~sel_reg[3:0];
            decoder_in <= pad_in[3:0] & pe_reg[3:0] & ~sel_reg[3:0];
            spi_in     <= pad_in[3:0] & pe_reg[3:0] & sel_reg[3:0];
            second_can_receive <= !(pe_reg[5] && sel_reg[5])
                                  || pad_in[5];
        end
    end

    // ----------------------------------------------------------------
    // Peripheral clock gating
    // ----------------------------------------------------------------

    // Enable registered to the peripherals, bit 15 EXTERNAL_MEMORY_INTERFACE to bit 0 PWM A
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            clk_en <= pfscg_pkg::PCE_RST;
        else
            clk_en <= pce_reg;
    end

    // Enable moves only while the clock is low, so no runt pulses
    always_ff @(negedge aclk)
    begin
        if (!aresetn)
            en_neg_reg <= pfscg_pkg::PCE_RST;
        else
            en_neg_reg <= pce_reg;
    end

    generate
        for (genvar k = 0; k < pfscg_pkg::PCE_W; k++)
        begin : g_gate
            assign periph_clk[k] = aclk & en_neg_reg[k];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_sel_reset;
        $rose(aresetn) |-> sel_reg[3:0] == 4'h0;
    endproperty
    a_sel_reset: assert property (p_sel_reset)
        else $error("port C select not decoder after reset");

    property p_pce_reset;
        $rose(aresetn) |-> clk_en == 16'hFFFF && pce_reg == 16'hFFFF;
    endproperty
    a_pce_reset: assert property (p_pce_reset)
        else $error("clock enables not all set after reset");

    property p_gpio_dir;
        !pe_reg[0] |=> pad_oe[0] == $past(dir_reg[0]);
    endproperty
    a_gpio_dir: assert property (p_gpio_dir)
        else $error("GPIO pad direction wrong");

    property p_timer_oe;
        pe_reg[1] && !sel_reg[1]
            |=> pad_oe[1] == $past(timer_output_enable[1]);
    endproperty
    a_timer_oe: assert property (p_timer_oe)
        else $error("timer drive enable not on pad");

    property p_spi_route;
        pe_reg[0] && sel_reg[0] |=> pad_out[0] == $past(spi_out[0]);
    endproperty
    a_spi_route: assert property (p_spi_route)
        else $error("SPI clock not routed to pad");

    property p_cs_drive;
        pe_reg[4] && !sel_reg[4]
            |=> pad_oe[4] && pad_out[4] == $past(chip_select_two);
    endproperty
    a_cs_drive: assert property (p_cs_drive)
        else $error("chip select pad not driven");

    property p_can_rx;
        pe_reg[5] && sel_reg[5]
            |=> !pad_oe[5] && second_can_receive == $past(pad_in[5]);
    endproperty
    a_can_rx: assert property (p_can_rx)
        else $error("CAN receive pad driven or not routed");

    property p_dec_in;
        pe_reg[2] && !sel_reg[2] |=> decoder_in[2] == $past(pad_in[2]);
    endproperty
    a_dec_in: assert property (p_dec_in)
        else $error("decoder input not following pad");

    property p_sel_read;
        s_axi_arvalid && s_axi_arready && ridx == 6'h0B
            |=> s_axi_rdata[31:6] == 26'h0000000
                && s_axi_rdata[5:0] == $past(sel_reg);
    endproperty
    a_sel_read: assert property (p_sel_read)
        else $error("select readback wrong");

    property p_clk_follow;
        do_write && widx == 6'h0C && wstrb_reg == 4'hF
            |=> ##1 clk_en == $past(wdata_reg[15:0], 2);
    endproperty
    a_clk_follow: assert property (p_clk_follow)
        else $error("clock enable did not follow write");

endmodule : pfscg_top

// *** pfscg_pkg.sv ***
package pfscg_pkg;

    // ----------------------------------------------------------------
    // Register map (indices; byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [5:0] SEL_IDX      = 6'h0B;
    localparam logic [5:0] PCE_IDX      = 6'h0C;
    localparam logic [5:0] PAD_CTL_IDX  = 6'h10;
    localparam logic [5:0] PAD_STAT_IDX = 6'h11;

    // ----------------------------------------------------------------
    // Field layout
    // ----------------------------------------------------------------
    localparam int SEL_W      = 6;
    localparam int PCE_W      = 16;
    localparam int NPAD       = 6;
    localparam int NPC        = 4;
    localparam int CTL_PE_LSB = 0;
    localparam int CTL_DIR_LSB = 8;
    localparam int PD0        = 4;
    localparam int PD1        = 5;

    // ----------------------------------------------------------------
    // Values after reset
    // ----------------------------------------------------------------
    localparam logic [SEL_W-1:0] SEL_RST     = 6'h00;
    localparam logic [PCE_W-1:0] PCE_RST     = 16'hFFFF;
    localparam logic [NPAD-1:0]  PE_RST      = 6'h0F;
    localparam logic [NPAD-1:0]  DIR_RST     = 6'h00;

    // ----------------------------------------------------------------
    // Bus answers
    // ----------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pfscg_pkg

// *** pfscg_periph_model.sv ***
`timescale 1ns/1ns
module pfscg_periph_model (
    input  wire logic [5:0]  pad_out,             // Pad drive values
    input  wire logic [5:0]  pad_oe,              // Pad drive enables
    input  wire logic [5:0]  ext_level,           // Off-chip pad level
    input  wire logic [18:0] stim,                // Peripheral pattern
    output logic [5:0]       pad_in,              // Resolved pad level
    output logic [3:0]       timer_out,           // Timer channels
    output logic [3:0]       timer_output_enable, // Timer drive
    output logic [3:0]       spi_out,             // SPI signals
    output logic [3:0]       spi_oe,              // SPI drive
    output logic             chip_select_two,     // Memory select 2
    output logic             chip_select_three,   // Memory select 3
    output logic             second_can_transmit  // CAN transmit
);
    // Peripheral outputs follow the pattern set by the bench
    assign timer_out           = stim[3:0];
    assign timer_output_enable = stim[7:4];
    assign spi_out             = stim[11:8];
    assign spi_oe              = stim[15:12];
    assign chip_select_two     = stim[16];
    assign chip_select_three   = stim[17];
    assign second_can_transmit = stim[18];
    // Wire level: chip drive wins, else the off-chip source
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule : pfscg_periph_model

// *** pfscg_tb.sv ***
`timescale 1ns/1ns
module testbench;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [5:0]  pad_in, pad_out, pad_oe, gpio_in;
    logic [5:0]  gpio_out = 6'h2B, ext_level = 6'h06;
    logic [3:0]  timer_out, timer_output_enable, timer_in, decoder_in;
    logic [3:0]  spi_out, spi_oe, spi_in;
    logic        chip_select_two, chip_select_three;
    logic        second_can_transmit, second_can_receive;
    logic [15:0] clk_en, periph_clk;
    logic [18:0] stim = 19'h1C55A;
    logic [31:0] rd;
    logic [3:0]  sel, e_oe, e_out, e_pad;
    int          mismatches = 0;
    int          n_compared = 0;

    pfscg_top i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe(pad_oe), .gpio_out(gpio_out), .gpio_in(gpio_in),
        .timer_out(timer_out), .timer_output_enable(timer_output_enable),
        .timer_in(timer_in), .decoder_in(decoder_in), .spi_out(spi_out),
        .spi_oe(spi_oe), .spi_in(spi_in),
        .chip_select_two(chip_select_two),
        .chip_select_three(chip_select_three),
        .second_can_transmit(second_can_transmit),
        .second_can_receive(second_can_receive), .clk_en(clk_en),
        .periph_clk(periph_clk));
    pfscg_periph_model i_periph (.pad_out(pad_out), .pad_oe(pad_oe),
        .ext_level(ext_level), .stim(stim), .pad_in(pad_in),
        .timer_out(timer_out), .timer_output_enable(timer_output_enable),
        .spi_out(spi_out), .spi_oe(spi_oe),
        .chip_select_two(chip_select_two),
        .chip_select_three(chip_select_three),
        .second_can_transmit(second_can_transmit));

    // 20 MHz clock
    always #25 aclk = ~aclk;

    // ------------------------------------------------------------
    // Bus tasks and checks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Address and data offered together, released as each is taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready === 1'b1)
            begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready === 1'b1)
            begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_read

    // Three edges cover the one- and two-cycle pad and enable lag
    task automatic settle;
        repeat (3) @(posedge aclk);
    endtask : settle

    task automatic results;
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results

    // Watchdog: the tests need well under a thousand cycles
    initial
    begin
        #(50 * 5000);
        mismatches++;
        results();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        axi_read(8'h2C);
        chk("select reset", rd, 32'h0);
        axi_read(8'h30);
        chk("clock enable reset", rd, 32'h0000FFFF);
        chk("clk_en reset", clk_en, 16'hFFFF);
        axi_read(8'h00);
        chk("unmapped read", resp, pfscg_pkg::RESP_SLVERR);
        axi_write(8'h2C, 32'hFFFFFFFF);
        chk("select write resp", resp, pfscg_pkg::RESP_OKAY);
        axi_read(8'h2C);
        chk("select read resp", resp, pfscg_pkg::RESP_OKAY);
        chk("select upper bits", rd, 32'h3F);
        $display("test reset_and_registers done");
        // Port C: one select bit at a time, last pass all decoder
        for (int i = 0; i < 5; i++)
        begin
            sel = 4'(5'b1 << i);
            axi_write(8'h2C, {28'h0, sel});
            settle();
            e_oe = (sel & spi_oe) | (~sel & timer_output_enable);
            e_out = (sel & spi_out) | (~sel & timer_out);
            e_pad = (e_oe & e_out) | (~e_oe & ext_level[3:0]);
            chk("port c drive", pad_oe[3:0], e_oe);
            chk("port c value", pad_out[3:0] & e_oe, e_out & e_oe);
            chk("spi in", spi_in, sel & e_pad);
            chk("timer in", timer_in, ~sel & e_pad);
            chk("decoder in", decoder_in, ~sel & e_pad);
        end
        $display("test port_c_select done");
        // Plain GPIO, mixed directions
        axi_write(8'h40, 32'h00001500);
        settle();
        chk("gpio drive", pad_oe, 6'h15);
        chk("gpio value", pad_out & 6'h15, gpio_out & 6'h15);
        chk("gpio in", gpio_in,
            (6'h15 & gpio_out) | (6'h2A & ext_level));
        $display("test gpio done");
        // Port D: memory selects, then second CAN
        axi_write(8'h40, 32'h00000030);
        axi_write(8'h2C, 32'h0);
        settle();
        chk("cs drive", pad_oe[5:4], 2'b11);
        chk("cs value", pad_out[5:4], 2'b01);
        axi_write(8'h2C, 32'h30);
        settle();
        chk("can drive", pad_oe[5:4], 2'b01);
        chk("can tx", pad_out[4], 1'b0);
        chk("can rx", second_can_receive, ext_level[5]);
        $display("test port_d done");
        // Clock gating
        axi_write(8'h30, 32'hFFFF5A5A);
        axi_read(8'h30);
        chk("clock enable read", rd, 32'h5A5A);
        settle();
        chk("clk_en", clk_en, 16'h5A5A);
        #10;
        chk("gated high", periph_clk, 16'h5A5A);
        @(negedge aclk);
        #10;
        chk("gated low", periph_clk, 16'h0);
        @(posedge aclk);
        axi_write(8'h00, 32'h1);
        chk("unmapped write", resp, pfscg_pkg::RESP_SLVERR);
        $display("test clock_gate done");
        results();
    end
endmodule : testbench
